// File: common/tbcf_defs.svh
`ifndef TBCF_DEFS_SVH
`define TBCF_DEFS_SVH

// ==========================================
// Register byte addresses
`define TBCF_ADDR_SECOND_CONTROL_REGISTER     8'h01
`define TBCF_ADDR_INTCTRL   8'h05
`define TBCF_ADDR_INTERRUPT_FLAG_REGISTER  8'h06
`define TBCF_ADDR_CAPTURE_EVENT_FLAG_LO   8'h0C
// ==========================================
// Field positions and reset values
`define TBCF_FLAG_BIT       0
`define TBCF_MODE_LSB       0
`define TBCF_MODE_W         3
`define TBCF_FLAGS_RESET    8'h00
`define TBCF_SECOND_CONTROL_REGISTER_RESET    8'h00
`define TBCF_MASK_RESET     8'h00

`endif

// File: common/tbcf_pkg.sv
package tbcf_pkg;

  typedef enum logic [2:0] {
    TBCF_MODE_PERIODIC,
    TBCF_MODE_TIMEOUT,
    TBCF_MODE_CAPTURE_EVENT_FLAG_EVENT,
    TBCF_MODE_CAPTURE_EVENT_FLAG_FREQ,
    TBCF_MODE_CAPTURE_EVENT_FLAG_PW,
    TBCF_MODE_CAPTURE_EVENT_FLAG_FRQPW,
    TBCF_MODE_SINGLE,
    TBCF_MODE_PWM8
  } tbcf_mode_t;

  // Strobes from the counter core, one cycle each
  typedef struct packed {
    logic top_hit;
    logic cmp_low_hit;
    logic capture_event_flag_load;
    logic edge_seen;
    logic cnt_stopped;
  } tbcf_evt_t;

endpackage

// File: hw/tbcf_flag.sv
`timescale 1ns/1ps
`include "tbcf_defs.svh"

// Summary of operation
// - Flag at bit 0 of offset 0x06
// - Write one clears; capture read clears in the four capture modes only
// - Counter mode selects the set condition
// - Periodic, timeout, single-shot: set at TOP
// - Event capture: set on capture load
// - Frequency capture: set on loading edge
// - Pulse-width capture: set on loading edge
// - Freq and width: set on an edge while the counter is stopped
// - 8-bit PWM: set at compare low byte
module tbcf_flag (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  input  wire tbcf_pkg::tbcf_evt_t evt_i,
  input  wire logic              capture_event_flag_read_i,
  output logic      [2:0]        counter_mode_select_o,
  output logic                   irq_o
);

  // ==========================================
  // Bus decode
  logic [7:0] second_control_register_reg;
  logic [7:0] mask_reg;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic       ack_reg;
  logic [31:0] rdat_reg;

  wire        acc     = cyc_i && stb_i && !ack_reg;
  // Writes land on the edge where the master samples ack high
  wire        wr      = cyc_i && stb_i && ack_reg && we_i && sel_i[0];
  wire        hit_ctl = adr_i == `TBCF_ADDR_SECOND_CONTROL_REGISTER;
  wire        hit_msk = adr_i == `TBCF_ADDR_INTCTRL;
  wire        hit_flg = adr_i == `TBCF_ADDR_INTERRUPT_FLAG_REGISTER;
  wire [7:0]  rsel    = hit_ctl ? second_control_register_reg :
                        hit_msk ? mask_reg  :
                        hit_flg ? flags_reg : 8'h00;

  // ==========================================
  // Set condition selection
  tbcf_pkg::tbcf_mode_t mode;
  assign mode = tbcf_pkg::tbcf_mode_t'(second_control_register_reg[`TBCF_MODE_LSB +: `TBCF_MODE_W]);
  assign counter_mode_select_o = second_control_register_reg[`TBCF_MODE_LSB +: `TBCF_MODE_W];

  logic set_cond;
  logic capture_event_flag_mode;
  always_comb begin
    set_cond  = 1'b0;
    capture_event_flag_mode = 1'b0;
    case (mode)
      tbcf_pkg::TBCF_MODE_PERIODIC,
      tbcf_pkg::TBCF_MODE_TIMEOUT,
      tbcf_pkg::TBCF_MODE_SINGLE: begin
        set_cond = evt_i.top_hit;
      end
      tbcf_pkg::TBCF_MODE_CAPTURE_EVENT_FLAG_EVENT: begin
        set_cond  = evt_i.capture_event_flag_load;
        capture_event_flag_mode = 1'b1;
      end
      tbcf_pkg::TBCF_MODE_CAPTURE_EVENT_FLAG_FREQ,
      tbcf_pkg::TBCF_MODE_CAPTURE_EVENT_FLAG_PW: begin
        set_cond  = evt_i.edge_seen && evt_i.capture_event_flag_load;
        capture_event_flag_mode = 1'b1;
      end
      tbcf_pkg::TBCF_MODE_CAPTURE_EVENT_FLAG_FRQPW: begin
        set_cond  = evt_i.edge_seen && evt_i.cnt_stopped;
        capture_event_flag_mode = 1'b1;
      end
      tbcf_pkg::TBCF_MODE_PWM8: begin
        set_cond = evt_i.cmp_low_hit;
      end
      default: begin
        set_cond = 1'b0;
      end
    endcase
  end

  wire clr_wr = wr && hit_flg && dat_i[`TBCF_FLAG_BIT];
  wire clr_rd = capture_event_flag_mode && capture_event_flag_read_i;
  wire clr    = clr_wr || clr_rd;

  always_comb begin
    flags_next = flags_reg;
    if (clr) begin
      flags_next[`TBCF_FLAG_BIT] = 1'b0;
    end
    if (set_cond) begin
      flags_next[`TBCF_FLAG_BIT] = 1'b1;
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg <= `TBCF_FLAGS_RESET;
      second_control_register_reg <= `TBCF_SECOND_CONTROL_REGISTER_RESET;
      mask_reg  <= `TBCF_MASK_RESET;
    end else begin
      flags_reg <= flags_next;
      if (wr && hit_ctl) begin
        second_control_register_reg <= {5'h00, dat_i[2:0]};
      end
      if (wr && hit_msk) begin
        mask_reg <= {7'h00, dat_i[0]};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg  <= acc;
      rdat_reg <= acc ? {24'h00_0000, rsel} : rdat_reg;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = rdat_reg;
  assign irq_o = |(flags_reg & mask_reg);

  // ==========================================
  // Check sequences
  sequence top_in_top_mode_s;
    (mode == tbcf_pkg::TBCF_MODE_PERIODIC || mode == tbcf_pkg::TBCF_MODE_SINGLE ||
     mode == tbcf_pkg::TBCF_MODE_TIMEOUT) && evt_i.top_hit;
  endsequence

  sequence capture_event_flag_event_load_s;
    mode == tbcf_pkg::TBCF_MODE_CAPTURE_EVENT_FLAG_EVENT && evt_i.capture_event_flag_load;
  endsequence

  sequence freq_edge_load_s;
    mode == tbcf_pkg::TBCF_MODE_CAPTURE_EVENT_FLAG_FREQ && evt_i.edge_seen && evt_i.capture_event_flag_load;
  endsequence

  sequence pw_edge_load_s;
    mode == tbcf_pkg::TBCF_MODE_CAPTURE_EVENT_FLAG_PW && evt_i.edge_seen && evt_i.capture_event_flag_load;
  endsequence

  sequence frqpw_stop_s;
    mode == tbcf_pkg::TBCF_MODE_CAPTURE_EVENT_FLAG_FRQPW && evt_i.edge_seen && evt_i.cnt_stopped;
  endsequence

  sequence pwm_low_hit_s;
    mode == tbcf_pkg::TBCF_MODE_PWM8 && evt_i.cmp_low_hit;
  endsequence

  sequence bus_request_s;
    cyc_i && stb_i && !ack_o;
  endsequence

  sequence write_one_clear_s;
    clr_wr && !set_cond;
  endsequence

  sequence capture_event_flag_read_clear_s;
    capture_event_flag_mode && capture_event_flag_read_i && !set_cond;
  endsequence

  // ==========================================
  // Reset checks
  flag_reset_a: assert property (@(posedge clk_i)
    rst_i
    |=> flags_reg == 8'h00)
    else $error("flag not cleared by reset");

  regs_reset_a: assert property (@(posedge clk_i)
    rst_i
    |=> second_control_register_reg == 8'h00 && mask_reg == 8'h00)
    else $error("control registers not cleared by reset");

  reset_quiet_a: assert property (@(posedge clk_i)
    rst_i
    |=> !ack_o && !irq_o)
    else $error("ack or irq active after reset");

  // ==========================================
  // Set condition checks
  top_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
    top_in_top_mode_s
    |=> flags_reg[0])
    else $error("TOP did not set flag");

  top_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode == tbcf_pkg::TBCF_MODE_PERIODIC && !evt_i.top_hit && !flags_reg[0]
    |=> !flags_reg[0])
    else $error("flag set without TOP");

  capture_event_flag_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
    capture_event_flag_event_load_s
    |=> flags_reg[0])
    else $error("capture load did not set flag");

  capture_event_flag_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode == tbcf_pkg::TBCF_MODE_CAPTURE_EVENT_FLAG_EVENT && !evt_i.capture_event_flag_load && !flags_reg[0]
    |=> !flags_reg[0])
    else $error("flag set without capture load");

  freq_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
    freq_edge_load_s
    |=> flags_reg[0])
    else $error("frequency edge did not set flag");

  freq_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode == tbcf_pkg::TBCF_MODE_CAPTURE_EVENT_FLAG_FREQ && !(evt_i.edge_seen && evt_i.capture_event_flag_load) &&
    !flags_reg[0] |=> !flags_reg[0])
    else $error("frequency flag set without loading edge");

  pw_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pw_edge_load_s
    |=> flags_reg[0])
    else $error("pulse width edge did not set flag");

  pw_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode == tbcf_pkg::TBCF_MODE_CAPTURE_EVENT_FLAG_PW && !(evt_i.edge_seen && evt_i.capture_event_flag_load) &&
    !flags_reg[0] |=> !flags_reg[0])
    else $error("pulse width flag set without loading edge");

  stop_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frqpw_stop_s
    |=> flags_reg[0])
    else $error("stop edge did not set flag");

  stop_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode == tbcf_pkg::TBCF_MODE_CAPTURE_EVENT_FLAG_FRQPW && !(evt_i.edge_seen && evt_i.cnt_stopped) &&
    !flags_reg[0] |=> !flags_reg[0])
    else $error("combined flag set without stop edge");

  pwm_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pwm_low_hit_s
    |=> flags_reg[0])
    else $error("compare low did not set flag");

  pwm_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode == tbcf_pkg::TBCF_MODE_PWM8 && !evt_i.cmp_low_hit && !flags_reg[0]
    |=> !flags_reg[0])
    else $error("pwm flag set without compare low");

  rise_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(flags_reg[0])
    |-> $past(set_cond))
    else $error("flag rose without set condition");

  // ==========================================
  // Clear checks
  wr1_clears_a: assert property (@(posedge clk_i) disable iff (rst_i)
    write_one_clear_s
    |=> !flags_reg[0])
    else $error("write one did not clear flag");

  wr0_keeps_a: assert property (@(posedge clk_i) disable iff (rst_i)
    flags_reg[0] && !clr
    |=> flags_reg[0])
    else $error("flag lost without clear");

  read_clears_a: assert property (@(posedge clk_i) disable iff (rst_i)
    capture_event_flag_read_clear_s
    |=> !flags_reg[0])
    else $error("capture read did not clear flag");

  read_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !capture_event_flag_mode && capture_event_flag_read_i && !clr_wr && flags_reg[0]
    |=> flags_reg[0])
    else $error("capture read cleared flag outside capture");

  set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    set_cond && clr
    |=> flags_reg[0])
    else $error("clear beat set");

  idle_stays_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !flags_reg[0] && !set_cond
    |=> !flags_reg[0])
    else $error("flag set without cause");

  upper_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
    flags_reg[7:1] == 7'h00)
    else $error("unused flag bits set");

  // ==========================================
  // Register checks
  mode_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit_ctl
    |=> counter_mode_select_o == $past(dat_i[2:0]))
    else $error("mode write not taken");

  ctrl_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && hit_ctl)
    |=> $stable(second_control_register_reg))
    else $error("mode changed without write");

  mask_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && hit_msk)
    |=> $stable(mask_reg))
    else $error("mask changed without write");

  irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == (flags_reg[0] && mask_reg[0]))
    else $error("irq does not follow flag and mask");

  // ==========================================
  // Bus checks
  ack_follows_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_request_s
    |=> ack_o)
    else $error("request not acknowledged");

  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o
    |=> !ack_o)
    else $error("ack longer than one cycle");

  ack_needs_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cyc_i && stb_i)
    |=> !ack_o)
    else $error("ack without request");

  read_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_request_s ##0 (hit_flg && !we_i)
    |=> dat_o[7:0] == $past(flags_reg))
    else $error("flag readback wrong");

  read_unmapped_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_request_s ##0 (!hit_ctl && !hit_msk && !hit_flg)
    |=> dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  dat_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cyc_i && stb_i && !ack_o)
    |=> $stable(dat_o))
    else $error("read data changed without access");

  rdata_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
    dat_o[31:8] == 24'h00_0000)
    else $error("read data upper bits set");

endmodule

// File: bench/test_tbcf_flag.sv
`timescale 1ns/1ps
module test_tbcf_flag;
  logic                clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic                capture_event_flag_read_i = 0, ack_o, irq_o;
  logic [7:0]          adr_i = 8'h00;
  logic [3:0]          sel_i = 4'h0;
  logic [31:0]         dat_i = 32'h0, dat_o, rd_v;
  logic [2:0]          counter_mode_select_o;
  tbcf_pkg::tbcf_evt_t evt_i = '0;
  int                  errors = 0, checks = 0, md = 0, msk = 0, flag = 0;
  tbcf_flag tbcf_flag_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .evt_i(evt_i), .capture_event_flag_read_i(capture_event_flag_read_i),
    .counter_mode_select_o(counter_mode_select_o), .irq_o(irq_o));
  initial forever #12.5 clk_i = ~clk_i;
  // ==========================================
  // Reference model of the flag
  always @(posedge clk_i) begin
    if (rst_i) begin
      flag = 0;
      md = 0;
      msk = 0;
    end else begin
      if ((md inside {0, 1, 6} && evt_i.top_hit) || (md == 2 && evt_i.capture_event_flag_load)
        || (md inside {3, 4} && evt_i.edge_seen && evt_i.capture_event_flag_load)
        || (md == 5 && evt_i.edge_seen && evt_i.cnt_stopped)
        || (md == 7 && evt_i.cmp_low_hit)) flag = 1;
      else if ((cyc_i && stb_i && we_i && ack_o && adr_i == 8'h06 && sel_i[0] && dat_i[0])
        || (capture_event_flag_read_i && md inside {[2:5]})) flag = 0;
      if (cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == 8'h01) md = dat_i[2:0];
      if (cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == 8'h05) msk = dat_i[0];
    end
  end
  // ==========================================
  // Checks and bus access
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task conclude;
    if (errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack_o !== 1'b1 && i < 20);
    rd_v = dat_o;
    if (i >= 20) begin
      errors++;
      conclude();
    end
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask
  always @(negedge clk_i)
    if (!rst_i) chk("irq", 32'(flag & msk), {31'h0, irq_o});
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(53));
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    bus(0, 8'h06, 32'h0);
    chk("flags", 32'h0, rd_v);
    for (int m = 0; m < 8; m++) begin
      bus(1, 8'h01, m);
      bus(1, 8'h05, 32'(m % 2));
      bus(1, 8'h06, 32'h1);
      bus(0, 8'h01, 32'h0);
      chk("ctrl", m, rd_v);
      chk("mode", m, {29'h0, counter_mode_select_o});
      repeat (60) begin
        evt_i <= 5'($urandom);
        capture_event_flag_read_i <= ($urandom % 4 == 0);
        @(posedge clk_i);
        if ($urandom % 8 == 0) begin
          evt_i <= '0;
          capture_event_flag_read_i <= 0;
          bus(1, 8'h06, 32'($urandom % 2));
        end
      end
      evt_i <= '0;
      capture_event_flag_read_i <= 0;
      bus(1, 8'h06, 32'h0);
      bus(0, 8'h06, 32'h0);
      chk("flags", flag, rd_v);
      bus(0, 8'h3F, 32'h0);
      chk("unmapped", 32'h0, rd_v);
    end
    conclude();
  end
endmodule
